//--- core/regulator_control_defs.vh
`ifndef REGULATOR_CONTROL_DEFS_VH
`define REGULATOR_CONTROL_DEFS_VH

// register offsets
`define BOOST_CTL_ADDR       8'h66
`define REFERENCE_CTL_ADDR   8'h6a
`define BACKUP_CTL_ADDR      8'h6b
`define LIN_ONE_CTL_ADDR     8'h6c
`define LIN_TWO_CTL_ADDR     8'h6d

// boost control field positions
`define BOOST_STBY_MODE_HI   6
`define BOOST_STBY_MODE_LO   5
`define BOOST_MODE_HI        3
`define BOOST_MODE_LO        2
`define BOOST_VOLT_HI        1
`define BOOST_VOLT_LO        0

// reference output and backup supply field positions
`define REFERENCE_EN_BIT     0
`define BACKUP_VOLT_HI       2
`define BACKUP_VOLT_LO       0

// linear regulator field positions, shared by both regulators
`define LIN_OFF_MODE_BIT     7
`define LIN_LOW_POWER_BIT    6
`define LIN_STANDBY_BIT      5
`define LIN_ENABLE_BIT       4
`define LIN_VOLT_HI          3
`define LIN_VOLT_LO          0

// boost switching mode codes
`define MODE_OFF             2'h0
`define MODE_PFM             2'h1
`define MODE_AUTO            2'h2
`define MODE_PULSE_SKIP      2'h3

// reset values and constants
`define REFERENCE_RESET      1'h0
`define BACKUP_VOLT_3V0      3'h6
`define LIN_TOP_RESET        3'h0
`define READ_ZERO            8'h00

// pin synchroniser depth
`define SYNC_STAGES          2

`endif

//--- core/pin_sync.v
`timescale 1ns/100ps
`include "regulator_control_defs.vh"

// two-flop synchroniser for pins; the first stage feeds only the second
module pin_sync #(
    parameter WIDTH = 4
) (
    input  wire             i_core_clk,
    input  wire             i_resetn,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

//--- core/regulator_control_registers.v
// Overview of operation
// RL1: boost standby mode field at bits 6:5
// RL2: boost normal mode field at bits 3:2
// RL3: boost voltage code at bits 1:0
// RL4: auto mode picks pfm or pulse-skip by load
// RL5: start-up enable forces boost normal mode auto
// RL6: marked fields reset from one-time-programmable values
// RL7: all registers readable and writable any time
// RL8: reference output enable bit 0, reset zero
// RL9: backup voltage code 110 only, default
// RL10: linear one bit 7 picks off or sleep
// RL11: linear one bit 6 allows low power
// RL12: linear one bit 5 turns off in standby
// RL13: linear one bit 4 enables regulator
// RL14: linear one bits 3:0 voltage code
// RL15: linear two same layout, top bits reset zero
// RL16: linear two bit 7 picks off or sleep
// RL17: reserved bits read zero, ignore writes
// RL18: writes act on outputs without commit step
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "regulator_control_defs.vh"

module regulator_control_registers (
    input  wire       i_core_clk,
    input  wire       i_resetn,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    input  wire [1:0] i_otp_boost_stby_mode,
    input  wire [1:0] i_otp_boost_mode,
    input  wire [1:0] i_otp_boost_volt,
    input  wire [2:0] i_otp_backup_volt,
    input  wire       i_otp_lin_one_enable,
    input  wire [3:0] i_otp_lin_one_volt,
    input  wire       i_otp_lin_two_enable,
    input  wire [3:0] i_otp_lin_two_volt,
    input  wire       i_boost_seq_enable,
    input  wire       i_en_pin,
    input  wire       i_standby_pin,
    input  wire       i_boost_light_load,
    input  wire       i_low_power_req,
    output reg  [7:0] o_rdata,
    output reg  [1:0] o_boost_op_mode,
    output reg  [1:0] o_boost_voltage_sel,
    output reg        o_reference_output_enable,
    output reg  [2:0] o_backup_supply_voltage_sel,
    output reg        o_linear_one_on,
    output reg        o_linear_one_sleep,
    output reg        o_linear_one_low_power,
    output reg  [3:0] o_linear_one_voltage_sel,
    output reg        o_linear_two_on,
    output reg        o_linear_two_sleep,
    output reg        o_linear_two_low_power,
    output reg  [3:0] o_linear_two_voltage_sel
);

    // boost control fields
    reg  [1:0] boost_standby_mode_sel_q;
    reg  [1:0] boost_normal_mode_sel_q;
    reg  [1:0] boost_voltage_sel_q;

    // reference output and backup supply fields
    reg        reference_output_enable_q;
    reg  [2:0] backup_supply_voltage_sel_q;

    // linear regulator one fields
    reg        linear_one_off_mode_q;
    reg        linear_one_low_power_en_q;
    reg        linear_one_standby_off_q;
    reg        linear_one_enable_q;
    reg  [3:0] linear_one_volt_q;

    // linear regulator two fields
    reg        linear_two_off_mode_q;
    reg        linear_two_low_power_en_q;
    reg        linear_two_standby_off_q;
    reg        linear_two_enable_q;
    reg  [3:0] linear_two_volt_q;

    reg  [7:0] rdata_d;
    reg  [2:0] lin_one_state;
    reg  [2:0] lin_two_state;

    wire [3:0] pins_sync;
    wire       en_pin_s;
    wire       standby_s;
    wire       light_load_s;
    wire       low_power_req_s;

    wire       wr_boost;
    wire       wr_reference;
    wire       wr_backup;
    wire       wr_lin_one;
    wire       wr_lin_two;

    wire       hit_boost;
    wire       hit_reference;
    wire       hit_backup;
    wire       hit_lin_one;
    wire       hit_lin_two;

    // every pin crosses into the core clock before any decision uses it
    // the synchroniser adds two edges of latency to every pin decision
    pin_sync #(
        .WIDTH      (4)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_async    ({i_low_power_req, i_boost_light_load, i_standby_pin, i_en_pin}),
        .o_sync     (pins_sync)
    );

    assign en_pin_s        = pins_sync[0];
    assign standby_s       = pins_sync[1];
    assign light_load_s    = pins_sync[2];
    assign low_power_req_s = pins_sync[3];

    // effective boost switching mode from the selected mode code
    function [1:0] boost_mode_resolve;
        input [1:0] sel;
        input       light;
        begin
            // light load gives pfm, heavier load gives pulse skipping
            if (sel == `MODE_AUTO) begin
                boost_mode_resolve = light ? `MODE_PFM : `MODE_PULSE_SKIP;
            end else begin
                boost_mode_resolve = sel;
            end
        end
    endfunction

    // linear regulator state as {on, sleep, low_power}
    function [2:0] lin_resolve;
        input enable;
        input off_mode;
        input standby_off;
        input low_power_en;
        input en_pin;
        input standby;
        input lp_req;
        reg   on;
        begin
            on          = 1'b0;
            lin_resolve = 3'h0;
            // priority: register enable, then enable pin, then standby
            if (!enable) begin
                lin_resolve = 3'h0;
            end else if (!en_pin) begin
                lin_resolve = {1'b0, off_mode, 1'b0};
            end else if (standby && standby_off) begin
                lin_resolve = 3'h0;
            end else begin
                on          = 1'b1;
                lin_resolve = {on, 1'b0, on & low_power_en & lp_req};
            end
        end
    endfunction

    // backup code accepted only if it names a real voltage
    function backup_code_ok;
        input [2:0] code;
        begin
            backup_code_ok = (code == `BACKUP_VOLT_3V0);
        end
    endfunction

    // full eight-bit match; a partial decode would alias onto unmapped offsets
    function addr_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // one decode shared by the write strobes and the read mux
    assign hit_boost     = addr_hit(i_addr, `BOOST_CTL_ADDR);
    assign hit_reference = addr_hit(i_addr, `REFERENCE_CTL_ADDR);
    assign hit_backup    = addr_hit(i_addr, `BACKUP_CTL_ADDR);
    assign hit_lin_one   = addr_hit(i_addr, `LIN_ONE_CTL_ADDR);
    assign hit_lin_two   = addr_hit(i_addr, `LIN_TWO_CTL_ADDR);

    // no mode gates either direction; every strobe is honoured except backup writes of a reserved code
    assign wr_boost     = i_wr && hit_boost;                           // RL7
    assign wr_reference = i_wr && hit_reference;
    assign wr_backup    = i_wr && hit_backup;
    assign wr_lin_one   = i_wr && hit_lin_one;
    assign wr_lin_two   = i_wr && hit_lin_two;

    // boost control register
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            boost_standby_mode_sel_q <= i_otp_boost_stby_mode;                // RL6
            boost_normal_mode_sel_q  <= i_otp_boost_mode;                     // RL6
            boost_voltage_sel_q      <= i_otp_boost_volt;                     // RL6
        end else begin
            if (wr_boost) begin
                boost_standby_mode_sel_q <=
                    i_wdata[`BOOST_STBY_MODE_HI:`BOOST_STBY_MODE_LO];         // RL1
                boost_voltage_sel_q <= i_wdata[`BOOST_VOLT_HI:`BOOST_VOLT_LO]; // RL3
            end
            // the sequencer wins the normal mode field over a write landing in the same cycle
            if (i_boost_seq_enable) begin
                boost_normal_mode_sel_q <= `MODE_AUTO;                        // RL5
            end else if (wr_boost) begin
                boost_normal_mode_sel_q <= i_wdata[`BOOST_MODE_HI:`BOOST_MODE_LO]; // RL2
            end
        end
    end

    // reference output and backup supply registers
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            reference_output_enable_q   <= `REFERENCE_RESET;                  // RL8
            backup_supply_voltage_sel_q <= i_otp_backup_volt;                 // RL6
        end else begin
            if (wr_reference) begin
                reference_output_enable_q <= i_wdata[`REFERENCE_EN_BIT];      // RL8
            end
            // a reserved code would drive the supply to an unknown level
            if (wr_backup &&
                backup_code_ok(i_wdata[`BACKUP_VOLT_HI:`BACKUP_VOLT_LO])) begin
                backup_supply_voltage_sel_q <=
                    i_wdata[`BACKUP_VOLT_HI:`BACKUP_VOLT_LO];                 // RL9
            end
        end
    end

    // linear regulator one register
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            linear_one_off_mode_q     <= 1'b0;
            linear_one_low_power_en_q <= 1'b0;
            linear_one_standby_off_q  <= 1'b0;
            linear_one_enable_q       <= i_otp_lin_one_enable;                // RL6
            linear_one_volt_q         <= i_otp_lin_one_volt;                  // RL6
        end else if (wr_lin_one) begin
            linear_one_off_mode_q     <= i_wdata[`LIN_OFF_MODE_BIT];          // RL10
            linear_one_low_power_en_q <= i_wdata[`LIN_LOW_POWER_BIT];         // RL11
            linear_one_standby_off_q  <= i_wdata[`LIN_STANDBY_BIT];           // RL12
            linear_one_enable_q       <= i_wdata[`LIN_ENABLE_BIT];            // RL13
            linear_one_volt_q         <= i_wdata[`LIN_VOLT_HI:`LIN_VOLT_LO];  // RL14
        end
    end

    // linear regulator two register, same layout as regulator one
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            {linear_two_off_mode_q, linear_two_low_power_en_q,
             linear_two_standby_off_q} <= `LIN_TOP_RESET;                     // RL15
            linear_two_enable_q       <= i_otp_lin_two_enable;                // RL6
            linear_two_volt_q         <= i_otp_lin_two_volt;                  // RL6
        end else if (wr_lin_two) begin
            linear_two_off_mode_q     <= i_wdata[`LIN_OFF_MODE_BIT];          // RL16
            linear_two_low_power_en_q <= i_wdata[`LIN_LOW_POWER_BIT];         // RL15
            linear_two_standby_off_q  <= i_wdata[`LIN_STANDBY_BIT];           // RL15
            linear_two_enable_q       <= i_wdata[`LIN_ENABLE_BIT];            // RL15
            linear_two_volt_q         <= i_wdata[`LIN_VOLT_HI:`LIN_VOLT_LO];  // RL15
        end
    end

    // read mux; unimplemented bits and unmapped offsets read as zero
    // the mux decodes every cycle; only the read strobe lets it reach o_rdata
    always @* begin
        rdata_d = `READ_ZERO;                                                 // RL17
        if (hit_boost) begin
            rdata_d[`BOOST_STBY_MODE_HI:`BOOST_STBY_MODE_LO] = boost_standby_mode_sel_q;
            rdata_d[`BOOST_MODE_HI:`BOOST_MODE_LO]           = boost_normal_mode_sel_q;
            rdata_d[`BOOST_VOLT_HI:`BOOST_VOLT_LO]           = boost_voltage_sel_q;
        end else if (hit_reference) begin
            rdata_d[`REFERENCE_EN_BIT] = reference_output_enable_q;
        end else if (hit_backup) begin
            rdata_d[`BACKUP_VOLT_HI:`BACKUP_VOLT_LO] = backup_supply_voltage_sel_q;
        end else if (hit_lin_one) begin
            rdata_d = {linear_one_off_mode_q, linear_one_low_power_en_q,
                       linear_one_standby_off_q, linear_one_enable_q,
                       linear_one_volt_q};
        end else if (hit_lin_two) begin
            rdata_d = {linear_two_off_mode_q, linear_two_low_power_en_q,
                       linear_two_standby_off_q, linear_two_enable_q,
                       linear_two_volt_q};
        end
    end

    // read data stands only in the cycle after the read strobe
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_rdata <= `READ_ZERO;
        end else if (i_rd) begin
            o_rdata <= rdata_d;                                               // RL7
        end else begin
            o_rdata <= `READ_ZERO;
        end
    end

    // regulator state decisions
    always @* begin
        lin_one_state = lin_resolve(linear_one_enable_q, linear_one_off_mode_q,
                                    linear_one_standby_off_q,
                                    linear_one_low_power_en_q, en_pin_s,
                                    standby_s, low_power_req_s);
        lin_two_state = lin_resolve(linear_two_enable_q, linear_two_off_mode_q,
                                    linear_two_standby_off_q,
                                    linear_two_low_power_en_q, en_pin_s,
                                    standby_s, low_power_req_s);
    end

    // outputs follow the stored fields and the synchronised pins, one register stage later
    // reset drives safe fixed levels; otp values show one edge after release
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_boost_op_mode             <= `MODE_OFF;
            o_boost_voltage_sel         <= 2'h0;
            o_reference_output_enable   <= 1'b0;
            o_backup_supply_voltage_sel <= `BACKUP_VOLT_3V0;
            o_linear_one_on             <= 1'b0;
            o_linear_one_sleep          <= 1'b0;
            o_linear_one_low_power      <= 1'b0;
            o_linear_one_voltage_sel    <= 4'h0;
            o_linear_two_on             <= 1'b0;
            o_linear_two_sleep          <= 1'b0;
            o_linear_two_low_power      <= 1'b0;
            o_linear_two_voltage_sel    <= 4'h0;
        end else begin
            o_boost_op_mode <= boost_mode_resolve(
                standby_s ? boost_standby_mode_sel_q : boost_normal_mode_sel_q,
                light_load_s);                                                // RL4
            o_boost_voltage_sel         <= boost_voltage_sel_q;               // RL18
            o_reference_output_enable   <= reference_output_enable_q;         // RL8
            o_backup_supply_voltage_sel <= backup_supply_voltage_sel_q;       // RL18
            o_linear_one_on             <= lin_one_state[2];                  // RL12
            o_linear_one_sleep          <= lin_one_state[1];                  // RL10
            o_linear_one_low_power      <= lin_one_state[0];                  // RL11
            o_linear_one_voltage_sel    <= linear_one_volt_q;                 // RL14
            o_linear_two_on             <= lin_two_state[2];                  // RL15
            o_linear_two_sleep          <= lin_two_state[1];                  // RL16
            o_linear_two_low_power      <= lin_two_state[0];                  // RL15
            o_linear_two_voltage_sel    <= linear_two_volt_q;                 // RL18
        end
    end

endmodule

//--- tb/regulator_control_monitor.sv
`timescale 1ns/100ps
`include "regulator_control_defs.vh"

module regulator_control_monitor (
    input wire       i_core_clk,
    input wire       i_resetn,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire       i_boost_seq_enable,
    input wire       i_standby_pin,
    input wire       i_boost_light_load,
    input wire [7:0] o_rdata,
    input wire [1:0] o_boost_op_mode,
    input wire [1:0] o_boost_voltage_sel,
    input wire       o_reference_output_enable,
    input wire [2:0] o_backup_supply_voltage_sel,
    input wire       o_linear_one_on,
    input wire       o_linear_one_sleep,
    input wire       o_linear_one_low_power,
    input wire [3:0] o_linear_two_voltage_sel
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_ref_wr;
        i_wr && i_addr == `REFERENCE_CTL_ADDR;
    endsequence
    sequence s_ref_rd;
        i_rd && i_addr == `REFERENCE_CTL_ADDR;
    endsequence
    a_rdata_idle_zero:
    assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle zero");
    a_ref_follows_write:
    assert property (s_ref_wr |=> ##1 o_reference_output_enable == $past(i_wdata[0], 2))
        else $error("reference enable did not follow write");
    a_ref_read_back:
    assert property (s_ref_wr ##1 s_ref_rd |=> o_rdata == {7'h00, $past(i_wdata[0], 2)})
        else $error("reference read back wrong");
    a_backup_refuse_code:
    assert property (i_wr && i_addr == `BACKUP_CTL_ADDR && i_wdata[2:0] != 3'h6
        |=> ##1 $stable(o_backup_supply_voltage_sel)) else $error("reserved backup code taken");
    a_boost_volt_write:
    assert property (i_wr && i_addr == `BOOST_CTL_ADDR
        |=> ##1 o_boost_voltage_sel == $past(i_wdata[1:0], 2)) else $error("boost volt wrong");
    a_boost_no_auto:
    assert property (o_boost_op_mode != `MODE_AUTO) else $error("auto code reached output");
    a_seq_forces_auto:
    assert property ((!i_standby_pin && !i_boost_light_load)[*4] ##0 i_boost_seq_enable
        |=> ##1 o_boost_op_mode == `MODE_PULSE_SKIP) else $error("start-up did not pick auto");
    a_lin_one_disabled:
    assert property (i_wr && i_addr == `LIN_ONE_CTL_ADDR && !i_wdata[4]
        |=> ##1 !(o_linear_one_on || o_linear_one_sleep || o_linear_one_low_power))
        else $error("disabled regulator one active");
    a_lin_two_volt:
    assert property (i_wr && i_addr == `LIN_TWO_CTL_ADDR
        |=> ##1 o_linear_two_voltage_sel == $past(i_wdata[3:0], 2)) else $error("lin two volt");
    a_boost_reserved_zero:
    assert property (i_rd && i_addr == `BOOST_CTL_ADDR |=> !o_rdata[7] && !o_rdata[4])
        else $error("boost reserved bits not zero");
endmodule

bind regulator_control_registers regulator_control_monitor mon (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_boost_seq_enable(i_boost_seq_enable),
    .i_standby_pin(i_standby_pin), .i_boost_light_load(i_boost_light_load),
    .o_rdata(o_rdata), .o_boost_op_mode(o_boost_op_mode),
    .o_boost_voltage_sel(o_boost_voltage_sel),
    .o_reference_output_enable(o_reference_output_enable),
    .o_backup_supply_voltage_sel(o_backup_supply_voltage_sel),
    .o_linear_one_on(o_linear_one_on), .o_linear_one_sleep(o_linear_one_sleep),
    .o_linear_one_low_power(o_linear_one_low_power),
    .o_linear_two_voltage_sel(o_linear_two_voltage_sel));

//--- tb/regulator_control_registers_test.sv
`timescale 1ns/100ps
`include "regulator_control_defs.vh"

module regulator_control_registers_test;
    logic       i_core_clk, i_resetn, i_wr, i_rd, i_boost_seq_enable, o_reference_output_enable;
    logic       i_en_pin, i_standby_pin, i_boost_light_load, i_low_power_req;
    logic [7:0] i_addr, i_wdata, o_rdata, q;
    logic [1:0] o_boost_op_mode, o_boost_voltage_sel, m, e;
    logic [2:0] o_backup_supply_voltage_sel;
    logic       o_linear_one_on, o_linear_one_sleep, o_linear_one_low_power;
    logic       o_linear_two_on, o_linear_two_sleep, o_linear_two_low_power;
    logic [3:0] o_linear_one_voltage_sel, o_linear_two_voltage_sel;
    int         miscompares, num_checks;
    logic [1:0] otp_stby = 2'h1, otp_mode = 2'h3, otp_volt = 2'h2;
    logic [2:0] otp_backup = 3'h6;
    logic [3:0] otp_one_volt = 4'h9, otp_two_volt = 4'h5;
    logic       otp_one_en = 1'b1, otp_two_en = 1'b0;
    // last offset is unmapped
    logic [7:0] addrs[6] = '{8'h66, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h67};
    logic [7:0] rst_exp[6] = '{8'h2e, 8'h00, 8'h06, 8'h19, 8'h05, 8'h00};
    logic [7:0] ff_exp[6] = '{8'h6f, 8'h01, 8'h06, 8'hff, 8'hff, 8'h00};
    // pins are {en, standby, low power request}; expected is {on, sleep, low power, volt}
    logic [7:0] lin_wv[7] = '{8'he3, 8'h7a, 8'h3a, 8'h7a, 8'h5a, 8'hda, 8'h5a};
    logic [2:0] lin_pins[7] = '{3'h5, 3'h5, 3'h5, 3'h7, 3'h6, 3'h1, 3'h1};
    logic [7:0] lin_exp[7] = '{8'h03, 8'h5a, 8'h4a, 8'h0a, 8'h4a, 8'h2a, 8'h0a};

    regulator_control_registers dut (
        .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_otp_boost_stby_mode(otp_stby), .i_otp_boost_mode(otp_mode),
        .i_otp_boost_volt(otp_volt), .i_otp_backup_volt(otp_backup),
        .i_otp_lin_one_enable(otp_one_en), .i_otp_lin_one_volt(otp_one_volt),
        .i_otp_lin_two_enable(otp_two_en), .i_otp_lin_two_volt(otp_two_volt),
        .i_boost_seq_enable(i_boost_seq_enable), .i_en_pin(i_en_pin),
        .i_standby_pin(i_standby_pin), .i_boost_light_load(i_boost_light_load),
        .i_low_power_req(i_low_power_req), .o_rdata(o_rdata), .o_boost_op_mode(o_boost_op_mode),
        .o_boost_voltage_sel(o_boost_voltage_sel),
        .o_reference_output_enable(o_reference_output_enable),
        .o_backup_supply_voltage_sel(o_backup_supply_voltage_sel),
        .o_linear_one_on(o_linear_one_on), .o_linear_one_sleep(o_linear_one_sleep),
        .o_linear_one_low_power(o_linear_one_low_power),
        .o_linear_one_voltage_sel(o_linear_one_voltage_sel),
        .o_linear_two_on(o_linear_two_on), .o_linear_two_sleep(o_linear_two_sleep),
        .o_linear_two_low_power(o_linear_two_low_power),
        .o_linear_two_voltage_sel(o_linear_two_voltage_sel));

    always #20 i_core_clk = ~i_core_clk;

    task chk(input logic [7:0] act, input logic [7:0] exp);
        num_checks++;
        if (act !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, act, exp);
        end
    endtask

    // called at a clock edge; returns at the edge that takes the write
    task wr(input logic [7:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    // data is sampled mid-cycle since it stands for one cycle only
    task rd(input logic [7:0] a, output logic [7:0] d);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(negedge i_core_clk);
        d = o_rdata;
        @(posedge i_core_clk);
    endtask

    task t_reset_values;
        for (int i = 0; i < 6; i++) begin
            rd(addrs[i], q);
            chk(q, rst_exp[i]);
        end
    endtask

    task t_all_ones;
        for (int i = 0; i < 6; i++) begin
            wr(addrs[i], 8'hff);
            rd(addrs[i], q);
            chk(q, ff_exp[i]);
        end
        chk({5'h00, o_backup_supply_voltage_sel}, 8'h06);
    endtask

    task t_reference_output;
        for (int v = 0; v < 2; v++) begin
            wr(`REFERENCE_CTL_ADDR, 8'(v));
            @(negedge i_core_clk);
            chk({7'h00, o_reference_output_enable}, 8'(1 - v));
            @(negedge i_core_clk);
            chk({7'h00, o_reference_output_enable}, 8'(v));
            @(posedge i_core_clk);
        end
    endtask

    task t_boost;
        for (int i = 0; i < 8; i++) begin
            m = i[1:0];
            i_standby_pin <= i[2];
            i_boost_light_load <= i[2];
            wr(`BOOST_CTL_ADDR, i[2] ? {1'b0, m, 3'h0, m} : {4'h0, m, m});
            e = (m == `MODE_AUTO) ? (i[2] ? `MODE_PFM : `MODE_PULSE_SKIP) : m;
            repeat (4) @(posedge i_core_clk);
            @(negedge i_core_clk);
            chk({4'h0, o_boost_op_mode, o_boost_voltage_sel}, {4'h0, e, m});
            @(posedge i_core_clk);
        end
        i_standby_pin <= 1'b0;
        i_boost_light_load <= 1'b0;
    endtask

    // a software mode write in the same cycle as the start-up enable must lose
    task t_seq;
        wr(`BOOST_CTL_ADDR, 8'h04);
        repeat (5) @(posedge i_core_clk);
        i_boost_seq_enable <= 1'b1;
        wr(`BOOST_CTL_ADDR, 8'h05);
        i_boost_seq_enable <= 1'b0;
        @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk({6'h00, o_boost_op_mode}, 8'h03);
        @(posedge i_core_clk);
        rd(`BOOST_CTL_ADDR, q);
        chk(q, 8'h09);
    endtask

    task t_linear;
        for (int r = 0; r < 2; r++) begin
            for (int j = 0; j < 7; j++) begin
                {i_en_pin, i_standby_pin, i_low_power_req} <= lin_pins[j];
                wr(r ? `LIN_TWO_CTL_ADDR : `LIN_ONE_CTL_ADDR, lin_wv[j]);
                repeat (4) @(posedge i_core_clk);
                @(negedge i_core_clk);
                q = r ? {1'b0, o_linear_two_on, o_linear_two_sleep, o_linear_two_low_power,
                    o_linear_two_voltage_sel} : {1'b0, o_linear_one_on, o_linear_one_sleep,
                    o_linear_one_low_power, o_linear_one_voltage_sel};
                chk(q, lin_exp[j]);
                @(posedge i_core_clk);
            end
        end
    endtask

    task results;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge i_core_clk);
        miscompares++;
        results;
    end

    initial begin
        {i_core_clk, i_resetn, i_wr, i_rd, i_boost_seq_enable} = 5'h00;
        {i_standby_pin, i_boost_light_load, i_low_power_req, i_en_pin} = 4'h1;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        repeat (20) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        t_reset_values;
        t_all_ones;
        t_reference_output;
        t_boost;
        t_seq;
        t_linear;
        results;
    end
endmodule
